// ---- shared/comp_cfg_if.sv ----
`default_nettype none
interface comp_cfg_if;
   logic [comp_pkg::TEMP_W-1:0] temperature_code;
   logic temp_comp_enable;
   logic [comp_pkg::SEG_N-1:0][2:0] slope_code;
   logic [comp_pkg::DIV_W-1:0] frame_division_factor;

   modport src (
      output temperature_code,
      output temp_comp_enable,
      output slope_code,
      output frame_division_factor
   );
   modport vop (
      input temperature_code,
      input temp_comp_enable,
      input slope_code
   );
   modport frame (
      input frame_division_factor
   );
endinterface
`default_nettype wire

// ---- shared/comp_pkg.sv ----
`default_nettype none
package comp_pkg;
   // ***********************************
   // Command bytes (flag low)
   // ***********************************
   localparam logic [7:0] CMD_RATE_OFF = 8'hbc;
   localparam logic [7:0] CMD_RATE_ON = 8'hbd;
   localparam logic [7:0] CMD_TCOMP_OFF = 8'hbe;
   localparam logic [7:0] CMD_TCOMP_ON = 8'hbf;
   localparam logic [7:0] CMD_SEG_DIV = 8'hc5;
   localparam logic [7:0] CMD_IDLE_DIV = 8'hc6;
   localparam logic [7:0] CMD_TEMP_READ = 8'hc8;

   // ***********************************
   // Division factors
   // ***********************************
   localparam int DIV_W = 7;
   localparam int SEG_N = 4;
   localparam logic [1:0] SEG_LAST = 2'h3;
   localparam logic [1:0] SEG_B = 2'h1;
   // Entry 0 is segment A
   localparam logic [SEG_N-1:0][DIV_W-1:0] DIV_SEG_RST = {7'h25, 7'h30, 7'h35, 7'h38};
   localparam logic [DIV_W-1:0] DIV_IDLE_RST = 7'h35;
   localparam logic RATE_EN_RST = 1'b1;
   localparam logic TCOMP_EN_RST = 1'b1;
   localparam logic [7:0] LINE_DIV = 8'h84;
   localparam logic [2:0] ROWS_FULL = 3'h4;
   localparam logic [2:0] ROWS_PARTIAL = 3'h1;

   // ***********************************
   // Temperature code and offset
   // ***********************************
   localparam int TEMP_W = 8;
   localparam logic [TEMP_W-1:0] TEMP_CODE_RST = 8'h40;
   localparam logic [TEMP_W-1:0] TEMP_CODE_MAX = 8'h7f;
   localparam logic [TEMP_W-1:0] SEG_B_START = 8'h20;
   localparam logic [TEMP_W-1:0] SEG_C_START = 8'h40;
   localparam logic [TEMP_W-1:0] SEG_D_START = 8'h60;
   localparam int OFF_W = 12;
   localparam logic signed [OFF_W-1:0] SPAN_S = 12'sh020;
   localparam logic signed [OFF_W-1:0] SEG_C_S = 12'sh040;
   localparam logic signed [OFF_W-1:0] SEG_D_S = 12'sh060;
   localparam int FRAC_BITS = 3;
   localparam logic signed [OFF_W-1:0] ROUND_HALF = 12'sh004;
   localparam int TRIM_W = 8;
   localparam int VOP_W = 9;
   localparam int SUM_W = 13;
   localparam logic signed [SUM_W-1:0] VOP_MAX = 13'sh01bd;

   // ***********************************
   // Timing
   // ***********************************
   localparam longint CLK_HZ = 200_000_000;
   localparam longint MEAS_INTERVAL_S = 10;
   localparam longint MEAS_INTERVAL_CYCLES = CLK_HZ * MEAS_INTERVAL_S;

   // Slope factor in eighths
   function automatic logic [3:0] slope_eighths(input logic [2:0] code);
      logic [3:0] f;
      f = 4'({1'b0, code}) + 4'h2;
      if (code == 3'h7) begin
         f = 4'ha;
      end
      return f;
   endfunction

   function automatic logic [1:0] segment_of(input logic [TEMP_W-1:0] code);
      logic [1:0] s;
      s = 2'h3;
      if (code < SEG_B_START) begin
         s = 2'h0;
      end else if (code < SEG_C_START) begin
         s = 2'h1;
      end else if (code < SEG_D_START) begin
         s = 2'h2;
      end
      return s;
   endfunction
endpackage
`default_nettype wire

// ---- verif/comp_chk.sv ----
`default_nettype none
module comp_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Host side
   input wire logic cmd_strobe,
   input wire logic cmd_dc,
   input wire logic [7:0] cmd_byte,
   input wire logic [7:0] rd_data_q,
   input wire logic rd_valid_q,
   // Modes and settings
   input wire logic partial_mode,
   input wire logic idle_mode,
   input wire logic [comp_pkg::VOP_W-1:0] base_voltage_code,
   input wire logic signed [comp_pkg::TRIM_W-1:0] contrast_trim,
   input wire logic signed [comp_pkg::TRIM_W-1:0] module_cal_trim,
   // Measurement
   input wire logic meas_done,
   input wire logic meas_start_q,
   input wire logic [comp_pkg::TEMP_W-1:0] temperature_code_q,
   // Results
   input wire logic [comp_pkg::VOP_W-1:0] lcd_operating_level_q,
   input wire logic signed [comp_pkg::TRIM_W-1:0] temp_offset_value_q,
   input wire logic [comp_pkg::DIV_W-1:0] frame_division_factor_q,
   input wire logic frame_tick_q,
   input wire logic [2:0] rows_simultaneous_q
);
   logic signed [comp_pkg::SUM_W-1:0] sum;
   logic [comp_pkg::VOP_W-1:0] sat_level;

   always_comb begin
      sum = $signed({4'h0, base_voltage_code}) + contrast_trim + module_cal_trim + temp_offset_value_q;
      sat_level = sum[comp_pkg::VOP_W-1:0];
      if (sum < 0) begin
         sat_level = 9'h000;
      end else if (sum > comp_pkg::VOP_MAX) begin
         sat_level = 9'h1bd;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_cmd(logic [7:0] code);
      cmd_strobe && !cmd_dc && cmd_byte == code;
   endsequence
   // Three quiet cycles flush any idle factor write in flight
   sequence s_idle_quiet;
      (idle_mode && !cmd_strobe) [*3];
   endsequence

   property p_sum;
      !$past(sys_rst) && $stable(base_voltage_code) && $stable(contrast_trim) && $stable(module_cal_trim)
         |-> lcd_operating_level_q == sat_level;
   endproperty
   property p_range;
      lcd_operating_level_q <= 9'h1bd;
   endproperty
   property p_rows;
      1'b1 |=> rows_simultaneous_q == ($past(partial_mode) ? 3'h1 : 3'h4);
   endproperty
   property p_idle;
      s_idle_quiet |=> $stable(frame_division_factor_q);
   endproperty
   property p_rd;
      s_cmd(comp_pkg::CMD_TEMP_READ) ##0 !meas_done |=> rd_valid_q && rd_data_q == temperature_code_q;
   endproperty
   property p_rd_only;
      rd_valid_q |-> $past(cmd_strobe && !cmd_dc && cmd_byte == comp_pkg::CMD_TEMP_READ);
   endproperty
   property p_meas;
      (s_cmd(comp_pkg::CMD_TCOMP_OFF) or s_cmd(comp_pkg::CMD_TCOMP_ON)) |-> ##2 meas_start_q;
   endproperty
   property p_start_pulse;
      meas_start_q |=> !meas_start_q;
   endproperty
   property p_temp;
      $changed(temperature_code_q) |-> $past(meas_done);
   endproperty
   property p_off;
      s_cmd(comp_pkg::CMD_TCOMP_OFF) |-> ##2 temp_offset_value_q == 8'sh00;
   endproperty
   property p_tick;
      frame_tick_q |=> !frame_tick_q [*8];
   endproperty

   a_sum: assert property (p_sum) else $error("level differs from saturated sum");
   a_range: assert property (p_range) else $error("level above ceiling");
   a_rows: assert property (p_rows) else $error("simultaneous row count wrong");
   a_idle: assert property (p_idle) else $error("idle factor moved");
   a_rd: assert property (p_rd) else $error("readback missing or wrong");
   a_rd_only: assert property (p_rd_only) else $error("readback without request");
   a_meas: assert property (p_meas) else $error("no measurement start");
   a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
   a_temp: assert property (p_temp) else $error("temperature code changed without result");
   a_off: assert property (p_off) else $error("offset not forced to zero");
   a_tick: assert property (p_tick) else $error("frame ticks too close");
endmodule

bind temp_comp_vop_frame_rate comp_chk u_comp_chk (.*);
`default_nettype wire

// ---- verif/host_model.sv ----
`default_nettype none
module host_model (
   // Clock
   input wire logic mclk,
   // Command bytes
   output logic cmd_strobe,
   output logic cmd_dc,
   output logic [7:0] cmd_byte
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_strobe = 1'b0;
      cmd_dc = 1'b0;
      cmd_byte = 8'h00;
   end

   task automatic send(input logic dc, input logic [7:0] b);
      @(negedge mclk);
      cmd_strobe <= 1'b1;
      cmd_dc <= dc;
      cmd_byte <= b;
   endtask

   task automatic quiet();
      @(negedge mclk);
      cmd_strobe <= 1'b0;
      // Released bus must not keep looking like the last byte
      cmd_byte <= ~cmd_byte;
   endtask

   task automatic cmd(input logic [7:0] b);
      send(1'b0, b);
      quiet();
   endtask

   // Bit 7 set on purpose; factors kept inside 20..127
   task automatic load_segs(input logic [6:0] a, input logic [6:0] b, input logic [6:0] c, input logic [6:0] d);
      send(1'b0, comp_pkg::CMD_SEG_DIV);
      send(1'b1, {1'b1, a});
      send(1'b1, {1'b1, b});
      send(1'b1, {1'b1, c});
      send(1'b1, {1'b1, d});
      quiet();
   endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_strobe;
   logic cmd_dc;
   logic [7:0] cmd_byte;
   logic [7:0] rd_data_q;
   logic rd_valid_q;
   logic partial_mode = 1'b0;
   logic idle_mode = 1'b0;
   logic [8:0] base_voltage_code = 9'h0a0;
   logic signed [7:0] contrast_trim = 8'sh05;
   logic signed [7:0] module_cal_trim = 8'shfd;
   logic [3:0][2:0] slope_code = {3'h0, 3'h6, 3'h2, 3'h7};
   logic meas_done = 1'b0;
   logic [7:0] meas_code = 8'h00;
   logic meas_start_q;
   logic [7:0] temperature_code_q;
   logic [8:0] lcd_operating_level_q;
   logic signed [7:0] temp_offset_value_q;
   logic [6:0] frame_division_factor_q;
   logic frame_tick_q;
   logic [2:0] rows_simultaneous_q;
   int bad_count = 0;
   int n_compared = 0;
   logic [6:0] seg_div [4] = '{7'h38, 7'h35, 7'h30, 7'h25};
   logic [6:0] idle_div = 7'h35;
   logic [7:0] codes [5] = '{8'h0a, 8'h22, 8'h46, 8'h64, 8'hc8};
   logic [7:0] cur = 8'h40;
   logic rate_en = 1'b1;
   logic comp_on = 1'b1;
   int n;

   always #2.5 mclk = ~mclk;

   host_model host (.*);

   temp_comp_vop_frame_rate #(.MEAS_INTERVAL_CYCLES(32'hc8)) dut (.*);

   // ***********************************
   // Expected values
   // ***********************************
   function automatic int e8(input logic [2:0] s);
      return (s == 3'h7) ? 10 : int'(s) + 2;
   endfunction

   function automatic int exp_off(input logic [7:0] c);
      int t;
      int x;
      t = (c > 8'h7f) ? 127 : int'(c);
      if (t < 32) x = 32 * e8(slope_code[1]) + e8(slope_code[0]) * (32 - t);
      else if (t < 64) x = (64 - t) * e8(slope_code[1]);
      else if (t < 96) x = -(t - 64) * e8(slope_code[2]);
      else x = -(32 * e8(slope_code[2]) + e8(slope_code[3]) * (t - 96));
      return (x + 4) >>> 3;
   endfunction

   function automatic int exp_lvl(input int off);
      int s;
      s = int'(base_voltage_code) + int'(contrast_trim) + int'(module_cal_trim) + off;
      return (s < 0) ? 0 : (s > 445) ? 445 : s;
   endfunction

   function automatic logic [6:0] exp_div(input logic [7:0] c);
      if (idle_mode) return idle_div;
      if (!rate_en) return seg_div[1];
      return seg_div[(c < 8'h20) ? 0 : (c < 8'h40) ? 1 : (c < 8'h60) ? 2 : 3];
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_all();
      int off;
      off = comp_on ? exp_off(cur) : 0;
      chk("temperature", 16'(cur), 16'(temperature_code_q));
      chk("offset", 16'(off), 16'(temp_offset_value_q));
      chk("level", 16'(exp_lvl(off)), 16'(lcd_operating_level_q));
      chk("factor", 16'(exp_div(cur)), 16'(frame_division_factor_q));
   endtask

   task automatic settle(input int k);
      repeat (k) @(negedge mclk);
      check_all();
   endtask

   task automatic wait_start();
      int i;
      for (i = 0; i < 300 && meas_start_q !== 1'b1; i++) @(negedge mclk);
      if (i >= 300) begin
         chk("meas_start", 16'h1, 16'h0);
         summarize();
      end
   endtask

   task automatic meas(input logic [7:0] c);
      host.cmd(comp_pkg::CMD_TCOMP_ON);
      wait_start();
      meas_done <= 1'b1;
      meas_code <= c;
      @(negedge mclk);
      meas_done <= 1'b0;
      meas_code <= ~c;
      cur = c;
      repeat (4) @(negedge mclk);
   endtask

   task automatic wait_tick(output int k);
      for (k = 1; k < 6000 && frame_tick_q !== 1'b1; k++) @(negedge mclk);
      if (k >= 6000) begin
         chk("frame_tick", 16'h1, 16'h0);
         summarize();
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ***********************************
   // Main sequence
   // ***********************************
   initial begin
      repeat (6) @(negedge mclk);
      sys_rst = 1'b0;
      settle(3);
      chk("rows", 16'h4, 16'(rows_simultaneous_q));
      foreach (codes[i]) begin
         meas(codes[i]);
         check_all();
         host.cmd(comp_pkg::CMD_TEMP_READ);
         chk("rd_valid", 16'h1, 16'(rd_valid_q));
         chk("rd_data", 16'(cur), 16'(rd_data_q));
      end
      host.load_segs(7'h54, 7'h1e, 7'h28, 7'h14);
      seg_div = '{7'h54, 7'h1e, 7'h28, 7'h14};
      settle(2);
      meas(8'h0a);
      host.cmd(comp_pkg::CMD_RATE_OFF);
      rate_en = 1'b0;
      settle(2);
      partial_mode = 1'b1;
      settle(2);
      chk("rows", 16'h1, 16'(rows_simultaneous_q));
      idle_mode = 1'b1;
      settle(2);
      host.send(1'b0, comp_pkg::CMD_IDLE_DIV);
      host.send(1'b1, 8'h94);
      host.quiet();
      idle_div = 7'h14;
      settle(2);
      wait_tick(n);
      @(negedge mclk);
      wait_tick(n);
      chk("frame_period", 16'(132 * 20), 16'(n));
      partial_mode = 1'b0;
      idle_mode = 1'b0;
      host.cmd(comp_pkg::CMD_RATE_ON);
      rate_en = 1'b1;
      wait_start();
      base_voltage_code = 9'h1b0;
      contrast_trim = 8'sh20;
      settle(2);
      base_voltage_code = 9'h000;
      contrast_trim = 8'sh80;
      settle(2);
      base_voltage_code = 9'h0a0;
      contrast_trim = 8'sh05;
      host.cmd(comp_pkg::CMD_TCOMP_OFF);
      comp_on = 1'b0;
      settle(3);
      summarize();
   end
endmodule
`default_nettype wire

// ---- verilog/frame_timer.sv ----
`default_nettype none
module frame_timer (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Division factor
   comp_cfg_if.frame cfg,
   // Frame start
   output logic frame_tick_q
);
   logic [7:0] line_cnt_q, line_cnt_d;
   logic [comp_pkg::DIV_W-1:0] div_cnt_q, div_cnt_d;
   logic frame_tick_d;

   // Frame = oscillator / line divider / division factor
   always_comb begin
      line_cnt_d = line_cnt_q + 8'h1;
      div_cnt_d = div_cnt_q;
      frame_tick_d = 1'b0;
      if (line_cnt_q >= comp_pkg::LINE_DIV - 8'h1) begin // R08
         line_cnt_d = '0;
         div_cnt_d = div_cnt_q + 7'h1;
         // >= so a factor lowered mid-frame ends the frame at the end of the current line
         if (div_cnt_q + 7'h1 >= cfg.frame_division_factor) begin // R08
            div_cnt_d = '0;
            frame_tick_d = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         line_cnt_q <= '0;
         div_cnt_q <= '0;
         frame_tick_q <= 1'b0;
      end else begin
         line_cnt_q <= line_cnt_d;
         div_cnt_q <= div_cnt_d;
         frame_tick_q <= frame_tick_d;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/temp_comp_vop_frame_rate.sv ----
// Notes on behaviour
// R01: Operating level is base code plus contrast trim, calibration trim and temperature offset.
// R02: The 13-bit sum saturates at 0 below and 445 above, never wraps.
// R03: Temperatures beyond the code range use the offset of the nearest end.
// R04: Temperature arrives as an 8-bit code, 0.9375 degree steps, and drives compensation.
// R05: The host reads the same temperature code through the command port.
// R06: Offset is piecewise over four 32-code segments using slope factors.
// R07: One offset unit moves the LCD voltage by one fixed step.
// R08: Frame rate is the oscillator over 132 then over the segment's factor.
// R09: Division factors are 7 bits; the host programs only 20 to 127.
// R10: Partial display mode uses the same segmented division factors.
// R11: Idle mode uses only the idle factor regardless of temperature.
// R12: Partial plus idle also uses the idle factor.
// R13: Command c5 then four parameter bytes load factors A to D; bit 7 ignored.
// R14: Command c6 then one parameter byte loads the idle factor; reset 35h.
// R15: Segment factors reset to 38h, 35h, 30h and 25h.
// R16: Four simultaneous rows in full display, one in partial display.
// R17: With segmented rate off, segment B factor is used at all temperatures.
// R18: With compensation off, the temperature offset is forced to zero.
// R19: Slope codes map to 0.25 up in eighths, 110 to 1.0, 111 to 1.25.
// R20: With compensation on, a measurement starts every ten seconds.
// R21: Frame segment uses the offset boundaries 32, 64 and 96.
// R22: Slope products are kept in eighths and rounded before the sum.
`default_nettype none
module temp_comp_vop_frame_rate #(
   parameter logic [31:0] MEAS_INTERVAL_CYCLES = 32'(comp_pkg::MEAS_INTERVAL_CYCLES)
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Host command bytes
   input wire logic cmd_strobe,
   input wire logic cmd_dc,
   input wire logic [7:0] cmd_byte,
   // Host readback
   output logic [7:0] rd_data_q,
   output logic rd_valid_q,
   // Display modes
   input wire logic partial_mode,
   input wire logic idle_mode,
   // Voltage settings
   input wire logic [comp_pkg::VOP_W-1:0] base_voltage_code,
   input wire logic signed [comp_pkg::TRIM_W-1:0] contrast_trim,
   input wire logic signed [comp_pkg::TRIM_W-1:0] module_cal_trim,
   input wire logic [comp_pkg::SEG_N-1:0][2:0] slope_code,
   // Temperature measurement
   input wire logic meas_done,
   input wire logic [comp_pkg::TEMP_W-1:0] meas_code,
   output logic meas_start_q,
   output logic [comp_pkg::TEMP_W-1:0] temperature_code_q,
   // Results
   output logic [comp_pkg::VOP_W-1:0] lcd_operating_level_q,
   output logic signed [comp_pkg::TRIM_W-1:0] temp_offset_value_q,
   output logic [comp_pkg::DIV_W-1:0] frame_division_factor_q,
   output logic frame_tick_q,
   output logic [2:0] rows_simultaneous_q
);
   typedef enum logic [1:0] {ST_CMD, ST_SEG_PARAM, ST_IDLE_PARAM} dec_state_t;

   // ***********************************
   // Command decoder state
   // ***********************************
   dec_state_t state_q, state_d;
   logic [1:0] param_idx_q, param_idx_d;
   logic [comp_pkg::SEG_N-1:0][comp_pkg::DIV_W-1:0] div_seg_q, div_seg_d;
   logic [comp_pkg::DIV_W-1:0] div_idle_q, div_idle_d;
   logic segmented_rate_enable_q, segmented_rate_enable_d;
   logic temp_comp_enable_q, temp_comp_enable_d;
   logic meas_req_q, meas_req_d;
   logic [7:0] rd_data_d;
   logic rd_valid_d;

   // ***********************************
   // Measurement state
   // ***********************************
   logic [31:0] interval_q, interval_d;
   logic meas_busy_q, meas_busy_d;
   logic meas_start_d;
   logic [comp_pkg::TEMP_W-1:0] temperature_code_d;
   logic meas_fire;

   // ***********************************
   // Frame factor selection state
   // ***********************************
   logic [comp_pkg::DIV_W-1:0] frame_division_factor_d;
   logic [2:0] rows_simultaneous_d;

   comp_cfg_if cfg ();

   assign cfg.temperature_code = temperature_code_q;
   assign cfg.temp_comp_enable = temp_comp_enable_q;
   assign cfg.slope_code = slope_code;
   assign cfg.frame_division_factor = frame_division_factor_q;

   // ***********************************
   // Command decoder
   // ***********************************
   always_comb begin
      state_d = state_q;
      param_idx_d = param_idx_q;
      div_seg_d = div_seg_q;
      div_idle_d = div_idle_q;
      segmented_rate_enable_d = segmented_rate_enable_q;
      temp_comp_enable_d = temp_comp_enable_q;
      meas_req_d = 1'b0;
      rd_data_d = rd_data_q;
      rd_valid_d = 1'b0;
      if (cmd_strobe && !cmd_dc) begin
         // Any command byte ends a pending parameter list
         state_d = ST_CMD;
         param_idx_d = '0;
         case (cmd_byte)
            comp_pkg::CMD_SEG_DIV: begin
               state_d = ST_SEG_PARAM; // R13
            end
            comp_pkg::CMD_IDLE_DIV: begin
               state_d = ST_IDLE_PARAM; // R14
            end
            comp_pkg::CMD_RATE_OFF: begin
               segmented_rate_enable_d = 1'b0;
            end
            comp_pkg::CMD_RATE_ON: begin
               segmented_rate_enable_d = 1'b1;
            end
            comp_pkg::CMD_TCOMP_OFF: begin
               temp_comp_enable_d = 1'b0;
               meas_req_d = 1'b1;
            end
            comp_pkg::CMD_TCOMP_ON: begin
               temp_comp_enable_d = 1'b1;
               meas_req_d = 1'b1;
            end
            comp_pkg::CMD_TEMP_READ: begin
               rd_data_d = temperature_code_q; // R05
               rd_valid_d = 1'b1;
            end
            default: begin
            end
         endcase
      end else if (cmd_strobe) begin
         unique case (state_q)
            ST_CMD: begin
               // Stray parameter bytes are dropped
            end
            ST_SEG_PARAM: begin
               // Bit 7 is don't care; range 20..127 is the host's duty
               div_seg_d[param_idx_q] = cmd_byte[comp_pkg::DIV_W-1:0]; // R13 R09
               param_idx_d = param_idx_q + 2'h1;
               if (param_idx_q == comp_pkg::SEG_LAST) begin
                  state_d = ST_CMD;
                  param_idx_d = '0;
               end
            end
            ST_IDLE_PARAM: begin
               div_idle_d = cmd_byte[comp_pkg::DIV_W-1:0]; // R14
               state_d = ST_CMD;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= ST_CMD;
         param_idx_q <= '0;
         div_seg_q <= comp_pkg::DIV_SEG_RST; // R15
         div_idle_q <= comp_pkg::DIV_IDLE_RST; // R14
         segmented_rate_enable_q <= comp_pkg::RATE_EN_RST;
         temp_comp_enable_q <= comp_pkg::TCOMP_EN_RST;
         meas_req_q <= 1'b0;
         rd_data_q <= '0;
         rd_valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         param_idx_q <= param_idx_d;
         div_seg_q <= div_seg_d;
         div_idle_q <= div_idle_d;
         segmented_rate_enable_q <= segmented_rate_enable_d;
         temp_comp_enable_q <= temp_comp_enable_d;
         meas_req_q <= meas_req_d;
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   // ***********************************
   // Measurement scheduling
   // ***********************************
   assign meas_fire = meas_req_q
                      || (temp_comp_enable_q && interval_q >= MEAS_INTERVAL_CYCLES - 32'h1); // R20

   always_comb begin
      interval_d = interval_q + 32'h1;
      meas_busy_d = meas_busy_q;
      meas_start_d = 1'b0;
      temperature_code_d = temperature_code_q;
      if (meas_done && meas_busy_q) begin
         temperature_code_d = meas_code; // R04
         meas_busy_d = 1'b0;
      end
      if (!temp_comp_enable_q) begin
         interval_d = '0;
      end
      // A new start wins over a completion in the same cycle
      if (meas_fire) begin
         interval_d = '0;
         meas_start_d = 1'b1;
         meas_busy_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         interval_q <= '0;
         meas_busy_q <= 1'b0;
         meas_start_q <= 1'b0;
         temperature_code_q <= comp_pkg::TEMP_CODE_RST;
      end else begin
         interval_q <= interval_d;
         meas_busy_q <= meas_busy_d;
         meas_start_q <= meas_start_d;
         temperature_code_q <= temperature_code_d;
      end
   end

   // ***********************************
   // Frame factor and row selection
   // ***********************************
   always_comb begin
      // Partial mode deliberately has no effect on this choice
      frame_division_factor_d = div_seg_q[comp_pkg::segment_of(temperature_code_q)]; // R21 R10
      if (!segmented_rate_enable_q) begin
         frame_division_factor_d = div_seg_q[comp_pkg::SEG_B]; // R17
      end
      if (idle_mode) begin
         frame_division_factor_d = div_idle_q; // R11 R12
      end
      rows_simultaneous_d = partial_mode ? comp_pkg::ROWS_PARTIAL : comp_pkg::ROWS_FULL; // R16
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         frame_division_factor_q <= comp_pkg::DIV_SEG_RST[comp_pkg::SEG_B];
         rows_simultaneous_q <= comp_pkg::ROWS_FULL;
      end else begin
         frame_division_factor_q <= frame_division_factor_d;
         rows_simultaneous_q <= rows_simultaneous_d;
      end
   end

   // ***********************************
   // Voltage sum and frame timing
   // ***********************************
   vop_offset_calc u_vop (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .cfg(cfg.vop),
      .base_voltage_code(base_voltage_code),
      .contrast_trim(contrast_trim),
      .module_cal_trim(module_cal_trim),
      .lcd_operating_level_q(lcd_operating_level_q),
      .temp_offset_value_q(temp_offset_value_q)
   );

   frame_timer u_frame (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .cfg(cfg.frame),
      .frame_tick_q(frame_tick_q)
   );
endmodule
`default_nettype wire

// ---- verilog/vop_offset_calc.sv ----
`default_nettype none
module vop_offset_calc (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Settings
   comp_cfg_if.vop cfg,
   input wire logic [comp_pkg::VOP_W-1:0] base_voltage_code,
   input wire logic signed [comp_pkg::TRIM_W-1:0] contrast_trim,
   input wire logic signed [comp_pkg::TRIM_W-1:0] module_cal_trim,
   // Results
   output logic [comp_pkg::VOP_W-1:0] lcd_operating_level_q,
   output logic signed [comp_pkg::TRIM_W-1:0] temp_offset_value_q
);
   logic [comp_pkg::SEG_N-1:0][3:0] fac;
   logic signed [comp_pkg::OFF_W-1:0] code_s;
   logic signed [comp_pkg::OFF_W-1:0] fa, fb, fc, fd;
   logic signed [comp_pkg::OFF_W-1:0] off8;
   logic signed [comp_pkg::OFF_W-1:0] off_r;
   logic signed [comp_pkg::SUM_W-1:0] sum;
   logic [comp_pkg::VOP_W-1:0] level_d;
   logic signed [comp_pkg::TRIM_W-1:0] offset_d;

   genvar i;
   generate
      for (i = 0; i < comp_pkg::SEG_N; i++) begin : g_fac
         assign fac[i] = comp_pkg::slope_eighths(cfg.slope_code[i]); // R19
      end
   endgenerate

   always_comb begin
      fa = comp_pkg::OFF_W'(fac[0]);
      fb = comp_pkg::OFF_W'(fac[1]);
      fc = comp_pkg::OFF_W'(fac[2]);
      fd = comp_pkg::OFF_W'(fac[3]);
      // Codes past the top end use the last valid offset
      code_s = comp_pkg::OFF_W'(cfg.temperature_code); // R04
      if (cfg.temperature_code > comp_pkg::TEMP_CODE_MAX) begin
         code_s = comp_pkg::OFF_W'(comp_pkg::TEMP_CODE_MAX); // R03
      end
      // Offset in eighths, so fractional slopes stay exact until rounding
      unique case (comp_pkg::segment_of(cfg.temperature_code)) // R06
         2'h0: off8 = (comp_pkg::SPAN_S * fb) + fa * (comp_pkg::SPAN_S - code_s);
         2'h1: off8 = (comp_pkg::SEG_C_S - code_s) * fb;
         2'h2: off8 = -((code_s - comp_pkg::SEG_C_S) * fc);
         2'h3: off8 = -((comp_pkg::SPAN_S * fc) + fd * (code_s - comp_pkg::SEG_D_S));
      endcase
      if (!cfg.temp_comp_enable) begin
         off8 = '0; // R18
      end
      off_r = (off8 + comp_pkg::ROUND_HALF) >>> comp_pkg::FRAC_BITS; // R22
      // One unit here is one voltage step downstream
      offset_d = comp_pkg::TRIM_W'(off_r); // R07
      sum = comp_pkg::SUM_W'({1'b0, base_voltage_code}) + comp_pkg::SUM_W'(contrast_trim)
            + comp_pkg::SUM_W'(module_cal_trim) + comp_pkg::SUM_W'(off_r); // R01
      if (sum < 0) begin
         level_d = '0; // R02
      end else if (sum > comp_pkg::VOP_MAX) begin
         level_d = comp_pkg::VOP_W'(comp_pkg::VOP_MAX); // R02
      end else begin
         level_d = sum[comp_pkg::VOP_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lcd_operating_level_q <= '0;
         temp_offset_value_q <= '0;
      end else begin
         lcd_operating_level_q <= level_d;
         temp_offset_value_q <= offset_d;
      end
   end
endmodule
`default_nettype wire
